// File: design/ats_pkg.sv
/*
 * package for the acquisition trigger select block: register map, field
 * codes, reset values and the carrier structs shared by the design.
 * assumes a plain one-cycle register port on the same clock as the block.
 */
package ats_pkg;

    // register byte addresses
    localparam logic [7:0] ATS_ADDR_MODE     = 8'h00; // trigger mode on/off
    localparam logic [7:0] ATS_ADDR_SOURCE   = 8'h04; // trigger source code
    localparam logic [7:0] ATS_ADDR_CMD      = 8'h08; // execute commands (write only)
    localparam logic [7:0] ATS_ADDR_CNT_SEL  = 8'h0C; // counter selector
    localparam logic [7:0] ATS_ADDR_CNT_EVT  = 8'h10; // counter event source
    localparam logic [7:0] ATS_ADDR_CNT_RST  = 8'h14; // counter reset source
    localparam logic [7:0] ATS_ADDR_CNT_DIV  = 8'h18; // counter divide value
    localparam logic [7:0] ATS_ADDR_CNT_CUR  = 8'h1C; // current count (read only)
    localparam logic [7:0] ATS_ADDR_STATUS   = 8'h20; // block status (read only)

    // command register bit positions
    localparam int ATS_CMD_SOFT_BIT = 0; // software execute
    localparam int ATS_CMD_CRST_BIT = 1; // counter reset execute

    // status register bit positions
    localparam int ATS_STAT_REFUSED_BIT = 0; // last counter reset was refused
    localparam int ATS_STAT_LINE0_BIT   = 1; // filtered isolated line level
    localparam int ATS_STAT_LINE2_BIT   = 2; // filtered bidirectional line level

    // widths
    localparam int ATS_DIV_W = 10;
    localparam int ATS_SRC_W = 3;

    // trigger source codes
    localparam logic [2:0] ATS_SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] ATS_SRC_LINE0    = 3'h1;
    localparam logic [2:0] ATS_SRC_LINE2    = 3'h2;
    localparam logic [2:0] ATS_SRC_COUNTER0 = 3'h3;
    localparam logic [2:0] ATS_SRC_ACTION1  = 3'h4;
    localparam logic [2:0] ATS_SRC_ANYWAY   = 3'h5;

    // counter event source codes
    localparam logic [1:0] ATS_EVT_OFF   = 2'h0;
    localparam logic [1:0] ATS_EVT_LINE0 = 2'h1;
    localparam logic [1:0] ATS_EVT_LINE2 = 2'h2;

    // counter reset source codes
    localparam logic ATS_CRST_OFF      = 1'b0;
    localparam logic ATS_CRST_SOFTWARE = 1'b1;

    // divide value limits and reset values
    localparam logic [9:0] ATS_DIV_MIN     = 10'h001;
    localparam logic [9:0] ATS_DIV_MAX     = 10'h3FF;
    localparam logic [9:0] ATS_DIV_RST     = 10'h001;
    localparam logic       ATS_MODE_RST    = 1'b0;
    localparam logic [2:0] ATS_SRC_RST     = 3'h0;
    localparam logic [9:0] ATS_COUNT_RST   = 10'h000;

    // configuration carrier
    typedef struct packed {
        logic            mode_on;
        logic [2:0]      source;
        logic [1:0]      cnt_evt;
        logic            cnt_rst_sw;
        logic [9:0]      cnt_div;
    } ats_cfg_type;

    // register port carrier
    typedef struct packed {
        logic [7:0]      addr;
        logic [31:0]     wdata;
        logic            wr;
        logic            rd;
    } ats_bus_type;

endpackage

// File: design/ats_top.sv
/*
 * acquisition trigger select: chooses between internal timing and one
 * external trigger source, and holds the single divide-by-n edge counter.
 * assumes the line inputs come from pins (asynchronous), the internal timing
 * tick and action command pulse come from logic on ref_clk_in, and software
 * uses a one-cycle register port with read data one cycle after the strobe.
 * software has already turned the bidirectional line to an input before
 * selecting it; the output side of that pin is handled elsewhere. there is
 * no interrupt: the current count and status are polled.
 */
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module ats_top
    import ats_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // trigger inputs
    input  wire logic        line0_in,
    input  wire logic        line2_in,
    input  wire logic        action_cmd_in,
    input  wire logic        internal_tick_in,
    // toward the acquisition sequencer
    output logic             acq_start_out,
    output logic             ext_mode_out
);

    // register port bundle and configuration
    ats_bus_type bus;
    ats_cfg_type cfg_r;
    ats_cfg_type cfg_nxt;

    // trigger lines: bit 0 isolated line, bit 1 bidirectional line
    logic [1:0]  pin_in;
    logic [1:0]  line_lvl;  // filtered levels, shown in status
    logic [1:0]  line_rise; // one-cycle rising edges of the filtered levels
    logic        l0_rise;
    logic        l2_rise;
    logic        hw_trig;

    // divide counter and its reset command
    logic        evt_edge;
    logic        cnt_trig;
    logic [9:0]  wdiv;      // divide value as it will be stored
    logic [9:0]  count_r;
    logic [9:0]  count_nxt;
    logic        refused_r;
    logic        refused_nxt;

    // execute command pulses
    logic        soft_cmd_r;
    logic        soft_cmd_nxt;
    logic        crst_cmd_r;
    logic        crst_cmd_nxt;

    // outputs toward the sequencer and software
    logic        acq_r;
    logic        acq_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // bundle the register port
    assign bus.addr  = reg_addr_in;
    assign bus.wdata = reg_wdata_in;
    assign bus.wr    = reg_wr_in;
    assign bus.rd    = reg_rd_in;

    // pin order for the line lanes
    assign pin_in = {line2_in, line0_in};

    // one lane per trigger pin: synchroniser, agreement filter, rising edge.
    // the level only moves once the second and third stages agree, so a pin
    // sampled mid-change cannot give a double edge
    generate
        for (genvar i = 0; i < 2; i++) begin : g_line
            logic [SYNC_STAGES-1:0] sync_r;
            logic [SYNC_STAGES-1:0] sync_nxt;
            logic                   lvl_r;
            logic                   lvl_nxt;

            // shift the pin in and filter the last two stages
            always_comb begin
                sync_nxt = {sync_r[SYNC_STAGES-2:0], pin_in[i]};
                lvl_nxt  = lvl_r;
                if (sync_r[SYNC_STAGES-2] == sync_r[SYNC_STAGES-1]) begin
                    lvl_nxt = sync_r[SYNC_STAGES-1];
                end
            end

            // lane registers; idle level low so reset makes no false edge
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    sync_r <= '0;
                    lvl_r  <= 1'b0;
                end else begin
                    sync_r <= sync_nxt;
                    lvl_r  <= lvl_nxt;
                end
            end

            // lane results
            assign line_lvl[i]  = lvl_r;
            assign line_rise[i] = lvl_nxt & ~lvl_r;
        end
    endgenerate

    // rising edges of the two lines by name
    assign l0_rise = line_rise[0];
    assign l2_rise = line_rise[1];

    // counter event comes from the selected line only
    always_comb begin
        unique case (cfg_r.cnt_evt)
            ATS_EVT_LINE0: evt_edge = l0_rise;
            ATS_EVT_LINE2: evt_edge = l2_rise;
            default:       evt_edge = 1'b0;    // off counts nothing
        endcase
    end

    // divide value write; zero is below the range and is stored as one,
    // otherwise a stored zero would read back although the compare triggers on every edge, the same as one
    always_comb begin
        wdiv = bus.wdata[ATS_DIV_W-1:0];
        if (wdiv < ATS_DIV_MIN) begin
            wdiv = ATS_DIV_MIN;
        end
    end

    // configuration registers written by software; an unknown source code,
    // event code 3 and writes to read-only offsets leave the settings alone
    always_comb begin
        cfg_nxt = cfg_r;
        if (bus.wr) begin
            unique case (bus.addr)
                ATS_ADDR_MODE:    cfg_nxt.mode_on = bus.wdata[0];
                ATS_ADDR_SOURCE: begin
                    if (bus.wdata[ATS_SRC_W-1:0] <= ATS_SRC_ANYWAY) begin
                        cfg_nxt.source = bus.wdata[ATS_SRC_W-1:0];
                    end
                end
                ATS_ADDR_CNT_EVT: begin
                    if (bus.wdata[1:0] != 2'h3) begin
                        cfg_nxt.cnt_evt = bus.wdata[1:0];
                    end
                end
                ATS_ADDR_CNT_RST: cfg_nxt.cnt_rst_sw = bus.wdata[0];
                ATS_ADDR_CNT_DIV: cfg_nxt.cnt_div = wdiv;
                default:          cfg_nxt = cfg_r;
            endcase
        end
    end

    // execute commands become one-cycle pulses; registering them costs a
    // cycle but keeps the strobe decode away from the start path
    always_comb begin
        soft_cmd_nxt = bus.wr && bus.addr == ATS_ADDR_CMD && bus.wdata[ATS_CMD_SOFT_BIT];
        crst_cmd_nxt = bus.wr && bus.addr == ATS_ADDR_CMD && bus.wdata[ATS_CMD_CRST_BIT];
    end

    // divide counter: one trigger per n counted edges, software reset.
    // an accepted reset command (reset source software) beats an event in the same cycle: the count restarts
    // and no trigger is issued, so software sees a clean zero afterwards
    always_comb begin
        count_nxt   = count_r;
        refused_nxt = refused_r;
        cnt_trig    = 1'b0;
        if (evt_edge) begin
            if (count_r + 10'h001 >= cfg_r.cnt_div) begin
                count_nxt = ATS_COUNT_RST;
                cnt_trig  = 1'b1;
            end else begin
                count_nxt = count_r + 10'h001;
            end
        end
        if (crst_cmd_r) begin
            if (cfg_r.cnt_rst_sw == ATS_CRST_SOFTWARE) begin
                count_nxt   = ATS_COUNT_RST;
                refused_nxt = 1'b0;
                cnt_trig    = 1'b0;
            end else begin
                refused_nxt = 1'b1;
            end
        end
    end

    // hardware line trigger for the anyway source: an edge on either line
    // counts, so the merged source takes either line but not the action command or the counter
    assign hw_trig = l0_rise | l2_rise;

    // trigger select: one pulse per accepted trigger. a trigger in the cycle
    // right after a pulse is dropped, so every start is followed by a low
    // cycle the sequencer can rely on
    always_comb begin
        acq_nxt = 1'b0;
        if (!cfg_r.mode_on) begin
            acq_nxt = internal_tick_in;
        end else begin
            unique case (cfg_r.source)
                ATS_SRC_SOFTWARE: acq_nxt = soft_cmd_r;
                ATS_SRC_LINE0:    acq_nxt = l0_rise;
                ATS_SRC_LINE2:    acq_nxt = l2_rise;
                ATS_SRC_COUNTER0: acq_nxt = cnt_trig;
                ATS_SRC_ACTION1:  acq_nxt = action_cmd_in;
                ATS_SRC_ANYWAY:   acq_nxt = soft_cmd_r | hw_trig;
                default:          acq_nxt = 1'b0;
            endcase
        end
        if (acq_r) begin
            acq_nxt = 1'b0;
        end
    end

    // read data mux, answer in the next cycle only; the command register
    // is write only and reads back zero like an unmapped offset
    always_comb begin
        rdata_nxt = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                ATS_ADDR_MODE:    rdata_nxt[0] = cfg_r.mode_on;
                ATS_ADDR_SOURCE:  rdata_nxt[ATS_SRC_W-1:0] = cfg_r.source;
                ATS_ADDR_CNT_SEL: rdata_nxt = '0;
                ATS_ADDR_CNT_EVT: rdata_nxt[1:0] = cfg_r.cnt_evt;
                ATS_ADDR_CNT_RST: rdata_nxt[0] = cfg_r.cnt_rst_sw;
                ATS_ADDR_CNT_DIV: rdata_nxt[ATS_DIV_W-1:0] = cfg_r.cnt_div;
                ATS_ADDR_CNT_CUR: rdata_nxt[ATS_DIV_W-1:0] = count_r;
                ATS_ADDR_STATUS: begin
                    rdata_nxt[ATS_STAT_REFUSED_BIT] = refused_r;
                    rdata_nxt[ATS_STAT_LINE0_BIT]   = line_lvl[0];
                    rdata_nxt[ATS_STAT_LINE2_BIT]   = line_lvl[1];
                end
                default:          rdata_nxt = '0;
            endcase
        end
    end

    // state registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cfg_r.mode_on    <= ATS_MODE_RST;
            cfg_r.source     <= ATS_SRC_RST;
            cfg_r.cnt_evt    <= ATS_EVT_OFF;
            cfg_r.cnt_rst_sw <= ATS_CRST_OFF;
            cfg_r.cnt_div    <= ATS_DIV_RST;
            count_r          <= ATS_COUNT_RST;
            refused_r        <= 1'b0;
            soft_cmd_r       <= 1'b0;
            crst_cmd_r       <= 1'b0;
            acq_r            <= 1'b0;
            rdata_r          <= '0;
        end else begin
            cfg_r            <= cfg_nxt;
            count_r          <= count_nxt;
            refused_r        <= refused_nxt;
            soft_cmd_r       <= soft_cmd_nxt;
            crst_cmd_r       <= crst_cmd_nxt;
            acq_r            <= acq_nxt;
            rdata_r          <= rdata_nxt;
        end
    end

    // outputs straight from flops
    assign reg_rdata_out = rdata_r;
    assign acq_start_out = acq_r;
    assign ext_mode_out  = cfg_r.mode_on;

endmodule

// File: test/ats_props.sv
/* checker for the acquisition trigger select block.
   sees only the top module ports; bound to every ats_top instance. */
`timescale 1ns/1ps
module ats_props
    import ats_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    // clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    // register port
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // triggers and sequencer side
    input wire logic        line0_in,
    input wire logic        line2_in,
    input wire logic        action_cmd_in,
    input wire logic        internal_tick_in,
    input wire logic        acq_start_out,
    input wire logic        ext_mode_out
);
    // one clock domain, reset masks everything
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // trigger pulses are isolated single cycles and follow the internal tick in internal mode
    a_pulse_single: assert property (acq_start_out |=> !acq_start_out)
        else $error("start pulse longer than one cycle");
    a_tick_internal: assert property (!ext_mode_out && internal_tick_in && !acq_start_out
        |=> acq_start_out)
        else $error("internal tick did not start acquisition");
    a_off_quiet: assert property ((!ext_mode_out)[*3] ##0 !$past(internal_tick_in)
        |-> !acq_start_out)
        else $error("start without tick in internal mode");
    // register side
    a_mode_write: assert property (reg_wr_in && reg_addr_in == ATS_ADDR_MODE
        |=> ext_mode_out == $past(reg_wdata_in[0]))
        else $error("mode write not reflected");
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data outside read slot");
    a_mode_read: assert property (reg_rd_in && reg_addr_in == ATS_ADDR_MODE
        |=> reg_rdata_out == {31'h0000_0000, ext_mode_out})
        else $error("mode readback wrong");
    a_sel_zero: assert property (reg_rd_in && reg_addr_in == ATS_ADDR_CNT_SEL
        |=> reg_rdata_out == 32'h0000_0000)
        else $error("counter selector not zero");
    a_unmapped_zero: assert property (reg_rd_in && reg_addr_in == 8'hFC
        |=> reg_rdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule

bind ats_top ats_props #(.SYNC_STAGES(SYNC_STAGES)) u_props (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .line0_in(line0_in), .line2_in(line2_in),
    .action_cmd_in(action_cmd_in), .internal_tick_in(internal_tick_in),
    .acq_start_out(acq_start_out), .ext_mode_out(ext_mode_out));

// File: test/ats_ext_model.sv
/* model of the trigger equipment: two pins, action pulse, internal tick.
   assumes it shares the block clock; lines rest low between pulses. */
`timescale 1ns/1ps
module ats_ext_model (
    // clock
    input  wire logic ref_clk_in,
    // toward the block
    output logic      line0_out,
    output logic      line2_out,
    output logic      action_out,
    output logic      tick_out
);
    // all sources idle at start
    initial begin
        line0_out = 1'b0;
        line2_out = 1'b0; // line two only ever acts as an input here
        action_out = 1'b0;
        tick_out = 1'b0;
    end

    // 0 line0, 1 line2, 2 action pulse, 3 tick; pins held 6 cycles
    task automatic pulse(input int k);
        @(posedge ref_clk_in);
        case (k)
            0: line0_out <= 1'b1;
            1: line2_out <= 1'b1;
            2: action_out <= 1'b1;
            default: tick_out <= 1'b1;
        endcase
        @(posedge ref_clk_in);
        action_out <= 1'b0;
        tick_out <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        line0_out <= 1'b0;
        line2_out <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
    endtask
endmodule

// File: test/ats_tb_top.sv
/* testbench for the acquisition trigger select block.
   drives the register port itself and the trigger pins through the model. */
`timescale 1ns/1ps
module ats_tb_top;
    import ats_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        l0, l2, act, tick, acq, ext;
    int          mismatches = 0;
    int          checks_done = 0;
    int          acq_n = 0;

    // 40 MHz clock and start pulse tally
    always #12.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (acq === 1'b1) acq_n <= acq_n + 1;

    ats_top uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .line0_in(l0), .line2_in(l2), .action_cmd_in(act), .internal_tick_in(tick),
        .acq_start_out(acq), .ext_mode_out(ext));
    ats_ext_model m (.ref_clk_in(ref_clk_in), .line0_out(l0), .line2_out(l2),
        .action_out(act), .tick_out(tick));

    // compare and verdict
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // register port cycles
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_in);
        rd <= 1'b1; addr <= a;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // one stimulus (4 = software execute), then count start pulses
    task automatic fire(input int k, input int n);
        int c;
        c = acq_n;
        if (k == 4) wrr(ATS_ADDR_CMD, 32'h0000_0001);
        else m.pulse(k);
        repeat (10) @(posedge ref_clk_in);
        chk(32'(acq_n - c), 32'(n));
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        mismatches++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        rdc(ATS_ADDR_MODE, 32'(ATS_MODE_RST));
        rdc(ATS_ADDR_SOURCE, 32'(ATS_SRC_SOFTWARE));
        rdc(ATS_ADDR_CNT_EVT, 32'(ATS_EVT_OFF));
        rdc(ATS_ADDR_CNT_RST, 32'(ATS_CRST_OFF));
        rdc(ATS_ADDR_CNT_DIV, 32'(ATS_DIV_RST));
        rdc(ATS_ADDR_CNT_CUR, 32'h0000_0000);
        rdc(ATS_ADDR_STATUS, 32'h0000_0000);
        rdc(ATS_ADDR_CNT_SEL, 32'h0000_0000);
        rdc(8'hFC, 32'h0000_0000);
        fire(3, 1);
        fire(4, 0);
        fire(0, 0);
        wrr(ATS_ADDR_MODE, 32'h0000_0001);
        fire(4, 1);
        fire(3, 0);
        fire(0, 0);
        wrr(ATS_ADDR_SOURCE, 32'(ATS_SRC_LINE0));
        fire(1, 0);
        fire(0, 1);
        wrr(ATS_ADDR_SOURCE, 32'(ATS_SRC_LINE2));
        fire(0, 0);
        fire(1, 1);
        wrr(ATS_ADDR_SOURCE, 32'(ATS_SRC_ACTION1));
        fire(2, 1);
        fire(4, 0);
        wrr(ATS_ADDR_SOURCE, 32'(ATS_SRC_ANYWAY));
        fire(4, 1);
        fire(0, 1);
        fire(1, 1);
        fire(2, 0);
        fire(3, 0);
        wrr(ATS_ADDR_CNT_EVT, 32'(ATS_EVT_LINE0));
        wrr(ATS_ADDR_CNT_DIV, 32'h0000_0003);
        wrr(ATS_ADDR_SOURCE, 32'(ATS_SRC_COUNTER0));
        fire(0, 0);
        fire(0, 0);
        rdc(ATS_ADDR_CNT_CUR, 32'h0000_0002);
        fire(0, 1);
        rdc(ATS_ADDR_CNT_CUR, 32'h0000_0000);
        fire(1, 0);
        fire(4, 0);
        fire(0, 0);
        wrr(ATS_ADDR_CMD, 32'h0000_0002);
        rdc(ATS_ADDR_CNT_CUR, 32'h0000_0001);
        rdc(ATS_ADDR_STATUS, 32'h0000_0001);
        wrr(ATS_ADDR_CNT_RST, 32'h0000_0001);
        wrr(ATS_ADDR_CMD, 32'h0000_0002);
        rdc(ATS_ADDR_CNT_CUR, 32'h0000_0000);
        rdc(ATS_ADDR_STATUS, 32'h0000_0000);
        wrr(ATS_ADDR_CNT_DIV, 32'h0000_03FF);
        rdc(ATS_ADDR_CNT_DIV, 32'h0000_03FF);
        wrr(ATS_ADDR_CNT_DIV, 32'h0000_0000);
        rdc(ATS_ADDR_CNT_DIV, 32'(ATS_DIV_MIN));
        fire(0, 1);
        rdc(ATS_ADDR_CNT_CUR, 32'h0000_0000);
        wrr(ATS_ADDR_CNT_EVT, 32'h0000_0003);
        rdc(ATS_ADDR_CNT_EVT, 32'(ATS_EVT_LINE0));
        wrr(ATS_ADDR_SOURCE, 32'h0000_0007);
        rdc(ATS_ADDR_SOURCE, 32'(ATS_SRC_COUNTER0));
        wrr(ATS_ADDR_MODE, 32'h0000_0000);
        fire(3, 1);
        fire(0, 0);
        summarize();
    end
endmodule
